// ### core/pfc_converter.v
// Power-to-pulse-frequency converter: per-phase products, low-pass, sum,
// digital-to-frequency conversion and pulse shaping for low-rate and calibration outputs.
// Assumes sample inputs are synchronous to clk_in and qualified by a strobe.
//
// Functional notes
// - Each phase's voltage and current samples are multiplied, low-pass filtered and summed into active power.
// - The two low-rate outputs give active-high pulses at a rate tracking average power through accumulation.
// - Low-rate frequency is 6.313 times the summed V*I products times the base frequency over Vref squared.
// - The base frequency is picked by scale, rate 1 and rate 0 as 2.24, 4.49, 1.12, 4.49, 5.09, 1.12, 0.56, 0.56 Hz.
// - Each base frequency is a division of the master clock so rates scale with that clock.
// - Full-scale ac inputs give the tabulated low-rate maximum for each select setting.
// - Full-scale ac inputs give exactly half the maximum rate that full-scale dc inputs give.
// - The calibration rate is the low-rate rate times 16, 8, 32, 16, 160, 16, 32 or 16 per setting.
// - The calibration maximum for ac inputs follows from the base rate and its multiplier per setting.
// - The calibration output uses the same power but a much shorter accumulation, so it follows instant power.
// - In delta mode total power is Ia times (Va-Vc) plus Ib times (Vb-Vc).
// - The low-rate outputs alternate with 120 ms pulses, half the period when the period is under 550 ms.
// - The calibration output gives 90 ms pulses, half the period when the period is under 190 ms.
`include "pfc_consts.vh"
`default_nettype none

module pfc_converter #(
  parameter SW = 16,
  parameter LPF_SHIFT = `PFC_LPF_SHIFT,
  parameter F_WIDTH_CYC = `PFC_MS_CYC(`PFC_F_WIDTH_MS),
  parameter F_MINPER_CYC = `PFC_MS_CYC(`PFC_F_MINPER_MS),
  parameter CAL_WIDTH_CYC = `PFC_MS_CYC(`PFC_CAL_WIDTH_MS),
  parameter CAL_MINPER_CYC = `PFC_MS_CYC(`PFC_CAL_MINPER_MS),
  parameter [31:0] DIV_SCALE = 32'h1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire scale_select_in,
  input wire rate_select_1_in,
  input wire rate_select_0_in,
  input wire delta_mode_in,
  input wire sample_valid_in,
  input wire signed [SW-1:0] volt_a_in,
  input wire signed [SW-1:0] volt_b_in,
  input wire signed [SW-1:0] volt_c_in,
  input wire signed [SW-1:0] curr_a_in,
  input wire signed [SW-1:0] curr_b_in,
  input wire signed [SW-1:0] curr_c_in,
  output wire low_rate_pulse_out_a_out,
  output wire low_rate_pulse_out_b_out,
  output wire calibration_pulse_out_out
);

  localparam PW = 2 * SW + 1;
  localparam AW = `PFC_ACC_W;

  // ========================================================================
  // Setting decode
  function [31:0] base_div;
    input [2:0] sel;
    begin
      case (sel)
        `PFC_SEL_000: base_div = `PFC_DIV(`PFC_FB_224);
        `PFC_SEL_100: base_div = `PFC_DIV(`PFC_FB_449);
        `PFC_SEL_001: base_div = `PFC_DIV(`PFC_FB_112);
        `PFC_SEL_101: base_div = `PFC_DIV(`PFC_FB_449);
        `PFC_SEL_010: base_div = `PFC_DIV(`PFC_FB_509);
        `PFC_SEL_110: base_div = `PFC_DIV(`PFC_FB_112);
        `PFC_SEL_011: base_div = `PFC_DIV(`PFC_FB_056);
        default: base_div = `PFC_DIV(`PFC_FB_056);
      endcase
    end
  endfunction

  function [AW-1:0] cal_threshold;
    input [2:0] sel;
    begin
      case (sel)
        `PFC_SEL_100: cal_threshold = `PFC_F_THRESHOLD / `PFC_CAL_R8;
        `PFC_SEL_001: cal_threshold = `PFC_F_THRESHOLD / `PFC_CAL_R32;
        `PFC_SEL_010: cal_threshold = `PFC_F_THRESHOLD / `PFC_CAL_R160;
        `PFC_SEL_011: cal_threshold = `PFC_F_THRESHOLD / `PFC_CAL_R32;
        default: cal_threshold = `PFC_F_THRESHOLD / `PFC_CAL_R16;
      endcase
    end
  endfunction

  // ========================================================================
  // Select capture, in the first cycle after reset and then only at low-rate accumulation boundaries
  reg [2:0] sel;
  reg sel_loaded;
  reg f_evt;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel <= `PFC_SEL_000;
      sel_loaded <= 1'b0;
    end else if (!sel_loaded || f_evt) begin
      sel <= {scale_select_in, rate_select_1_in, rate_select_0_in};
      sel_loaded <= 1'b1;
    end
  end

  // ========================================================================
  // Per-phase products and low-pass filters
  wire signed [SW-1:0] volt [0:2];
  wire signed [SW-1:0] curr [0:2];
  wire signed [PW-1:0] lp_out [0:2];
  assign volt[0] = volt_a_in;
  assign volt[1] = volt_b_in;
  assign volt[2] = volt_c_in;
  assign curr[0] = curr_a_in;
  assign curr[1] = curr_b_in;
  assign curr[2] = curr_c_in;

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_phase
      wire signed [SW:0] v_ext;
      wire signed [SW:0] v_use;
      wire signed [PW-1:0] prod;
      wire signed [PW:0] diff;
      reg signed [PW-1:0] lp;
      assign v_ext = {volt[p][SW-1], volt[p]};
      // Delta: phase C is the voltage reference and carries no current term
      assign v_use = !delta_mode_in ? v_ext :
                     (p == 2) ? {(SW+1){1'b0}} :
                     v_ext - {volt[2][SW-1], volt[2]};
      assign prod = v_use * curr[p];
      assign diff = {prod[PW-1], prod} - {lp[PW-1], lp};
      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          lp <= {PW{1'b0}};
        end else if (sample_valid_in) begin
          // Sign-extend the scaled step so falling power pulls the filter down
          lp <= lp + {{(LPF_SHIFT-1){diff[PW]}}, diff[PW:LPF_SHIFT]};
        end
      end
      assign lp_out[p] = lp;
    end
  endgenerate

  // Sum; negative totals add nothing so no pulses are issued
  wire signed [PW+1:0] power_sum;
  wire [AW-1:0] power_pos;
  assign power_sum = {{2{lp_out[0][PW-1]}}, lp_out[0]} + {{2{lp_out[1][PW-1]}}, lp_out[1]} +
                     {{2{lp_out[2][PW-1]}}, lp_out[2]};
  assign power_pos = power_sum[PW+1] ? {AW{1'b0}} : {{(AW-PW-2){1'b0}}, power_sum};

  // ========================================================================
  // Base-rate tick from the master clock
  reg [31:0] div_cnt;
  reg tick;
  wire [31:0] div_load;
  assign div_load = base_div(sel) / DIV_SCALE;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (!sel_loaded) begin
      // Wait for the setting so the first period already uses it
      div_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (div_cnt == 32'h0) begin
      div_cnt <= div_load - 32'h1;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt - 32'h1;
      tick <= 1'b0;
    end
  end

  // ========================================================================
  // Digital-to-frequency accumulators
  // Full-scale ac averages to half the dc product, so ac max is half dc max
  reg [AW-1:0] f_acc;
  reg [AW-1:0] cal_acc;
  reg cal_evt;
  wire [AW-1:0] f_sum;
  wire [AW-1:0] cal_sum;
  wire [AW-1:0] cal_thr;
  assign f_sum = f_acc + power_pos;
  assign cal_sum = cal_acc + power_pos;
  assign cal_thr = cal_threshold(sel);
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      f_acc <= {AW{1'b0}};
      cal_acc <= {AW{1'b0}};
      f_evt <= 1'b0;
      cal_evt <= 1'b0;
    end else begin
      f_evt <= 1'b0;
      cal_evt <= 1'b0;
      if (tick) begin
        // Long accumulation averages out the double-line-frequency ripple
        if (f_sum >= `PFC_F_THRESHOLD) begin
          f_acc <= f_sum - `PFC_F_THRESHOLD;
          f_evt <= 1'b1;
        end else begin
          f_acc <= f_sum;
        end
        // Threshold divided by the multiplier: shorter interval, less averaging
        if (cal_sum >= cal_thr) begin
          cal_acc <= cal_sum - cal_thr;
          cal_evt <= 1'b1;
        end else begin
          cal_acc <= cal_sum;
        end
      end
    end
  end

  // ========================================================================
  // Output pulse shaping
  pfc_pulse_shaper #(
    .CW(32),
    .WIDTH_CYC(F_WIDTH_CYC),
    .MINPER_CYC(F_MINPER_CYC),
    .ALTERNATE(1)
  ) u_low_rate (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .event_in(f_evt),
    .pulse_a_out(low_rate_pulse_out_a_out),
    .pulse_b_out(low_rate_pulse_out_b_out)
  );

  pfc_pulse_shaper #(
    .CW(32),
    .WIDTH_CYC(CAL_WIDTH_CYC),
    .MINPER_CYC(CAL_MINPER_CYC),
    .ALTERNATE(0)
  ) u_calib (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .event_in(cal_evt),
    .pulse_a_out(calibration_pulse_out_out),
    .pulse_b_out()
  );

endmodule // pfc_converter

`default_nettype wire

// ### inc/pfc_consts.vh
// Constants for the power-to-pulse-frequency converter.
// Assumes a single 100 MHz master clock; every rate below is derived from it.
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH

// ==========================================================================
// Clock and base-rate divider
`define PFC_CLK_HZ 100000000
`define PFC_TICKS_PER_BASE 1024
// Base frequencies in millihertz
`define PFC_FB_224 2240
`define PFC_FB_449 4490
`define PFC_FB_112 1120
`define PFC_FB_509 5090
`define PFC_FB_056 560
`define PFC_DIV(fmhz) (((`PFC_CLK_HZ / `PFC_TICKS_PER_BASE) * 1000) / (fmhz))

// ==========================================================================
// Select codes, ordered scale, rate 1, rate 0
`define PFC_SEL_000 3'h0
`define PFC_SEL_001 3'h1
`define PFC_SEL_010 3'h2
`define PFC_SEL_011 3'h3
`define PFC_SEL_100 3'h4
`define PFC_SEL_101 3'h5
`define PFC_SEL_110 3'h6
`define PFC_SEL_111 3'h7

// ==========================================================================
// Accumulator threshold: ticks_per_base * 2^30 * Vref^2 / (6.313 * 0.25)
`define PFC_ACC_W 48
`define PFC_F_THRESHOLD 48'h03A64CCCCCCC
`define PFC_CAL_R8 8
`define PFC_CAL_R16 16
`define PFC_CAL_R32 32
`define PFC_CAL_R160 160

// ==========================================================================
// Pulse timing
`define PFC_F_WIDTH_MS 120
`define PFC_F_MINPER_MS 550
`define PFC_CAL_WIDTH_MS 90
`define PFC_CAL_MINPER_MS 190
`define PFC_MS_CYC(ms) ((ms) * (`PFC_CLK_HZ / 1000))
`define PFC_LPF_SHIFT 10

`endif

// ### core/pfc_pulse_shaper.v
// Pulse shaper: turns one-cycle events into timed high pulses, optionally alternating.
// Assumes events are at most one per cycle and come from the same clock.
`default_nettype none

module pfc_pulse_shaper #(
  parameter CW = 32,
  parameter WIDTH_CYC = 1000,
  parameter MINPER_CYC = 2000,
  parameter ALTERNATE = 1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire event_in,
  output reg pulse_a_out,
  output reg pulse_b_out
);

  // ========================================================================
  // Period measurement and width counter
  reg [CW-1:0] per_cnt;
  reg [CW-1:0] hi_cnt;
  reg lane;
  reg [CW-1:0] next_width;

  // Short period sets the width to half the period; never below one cycle
  always @* begin
    if (per_cnt < MINPER_CYC[CW-1:0]) begin
      next_width = per_cnt >> 1;
    end else begin
      next_width = WIDTH_CYC[CW-1:0];
    end
    if (next_width == {CW{1'b0}}) begin
      next_width = {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      per_cnt <= {CW{1'b1}};
      hi_cnt <= {CW{1'b0}};
      lane <= 1'b0;
      pulse_a_out <= 1'b0;
      pulse_b_out <= 1'b0;
    end else if (event_in) begin
      per_cnt <= {{(CW-1){1'b0}}, 1'b1};
      hi_cnt <= next_width;
      if (ALTERNATE != 0) begin
        lane <= ~lane;
      end
      pulse_a_out <= ~lane || (ALTERNATE == 0);
      pulse_b_out <= lane && (ALTERNATE != 0);
    end else begin
      if (per_cnt != {CW{1'b1}}) begin
        per_cnt <= per_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
      if (hi_cnt != {CW{1'b0}}) begin
        hi_cnt <= hi_cnt - {{(CW-1){1'b0}}, 1'b1};
      end
      if (hi_cnt <= {{(CW-1){1'b0}}, 1'b1}) begin
        pulse_a_out <= 1'b0;
        pulse_b_out <= 1'b0;
      end
    end
  end

endmodule // pfc_pulse_shaper

`default_nettype wire

// ### verification/pfc_conv_asserts.sv
// Checker for the converter pulse outputs.
// Assumes it is bound into pfc_converter and sees only its ports.
`default_nettype none
module pfc_conv_asserts #(
  parameter int F_WIDTH_CYC = 40,
  parameter int F_MINPER_CYC = 200,
  parameter int CAL_WIDTH_CYC = 30,
  parameter int CAL_MINPER_CYC = 70
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic low_rate_pulse_out_a_out,
  input wire logic low_rate_pulse_out_b_out,
  input wire logic calibration_pulse_out_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire a = low_rate_pulse_out_a_out;
  wire b = low_rate_pulse_out_b_out;
  wire f = a | b;
  wire c = calibration_pulse_out_out;
  int fg, fl, fe, cg, cl, ce;
  logic fp, cp, b_last;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // Period and width trackers; first pulse after reset is full width
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fg <= F_MINPER_CYC;
      cg <= CAL_MINPER_CYC;
      fl <= 0;
      cl <= 0;
      fe <= F_WIDTH_CYC;
      ce <= CAL_WIDTH_CYC;
      fp <= 1'h0;
      cp <= 1'h0;
      b_last <= 1'h1;
    end else begin
      fp <= f;
      cp <= c;
      fl <= f ? fl + 1 : 0;
      cl <= c ? cl + 1 : 0;
      fg <= (f && !fp) ? 1 : (fg < F_MINPER_CYC ? fg + 1 : fg);
      cg <= (c && !cp) ? 1 : (cg < CAL_MINPER_CYC ? cg + 1 : cg);
      if (f && !fp)
        fe <= (fg >= F_MINPER_CYC) ? F_WIDTH_CYC : ((fg / 2 > 0) ? fg / 2 : 1);
      if (c && !cp)
        ce <= (cg >= CAL_MINPER_CYC) ? CAL_WIDTH_CYC : ((cg / 2 > 0) ? cg / 2 : 1);
      b_last <= a ? 1'h0 : (b ? 1'h1 : b_last);
    end
  end
  // ==========================================================
  // Properties
  sequence s_f_full;
    $rose(f) ##0 (fg >= F_MINPER_CYC);
  endsequence
  sequence s_c_full;
    $rose(c) ##0 (cg >= CAL_MINPER_CYC);
  endsequence
  property p_reset_quiet;
    $rose(rst_n_in) |-> !f && !c;
  endproperty
  property p_f_width;
    $fell(f) |-> (fl >= fe - 1) && (fl <= fe + 1);
  endproperty
  property p_cal_width;
    $fell(c) |-> (cl >= ce - 1) && (cl <= ce + 1);
  endproperty
  property p_a_turn;
    $rose(a) |-> b_last;
  endproperty
  property p_b_turn;
    $rose(b) |-> !b_last;
  endproperty
  property p_lanes_apart;
    !(a && b);
  endproperty
  property p_f_hold;
    s_f_full |=> f [*8];
  endproperty
  property p_cal_hold;
    s_c_full |=> c [*8];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pulse right after reset");
  a_f_width: assert property (p_f_width) else $error("low rate width wrong");
  a_cal_width: assert property (p_cal_width) else $error("calibration width wrong");
  a_a_turn: assert property (p_a_turn) else $error("lane a out of turn");
  a_b_turn: assert property (p_b_turn) else $error("lane b out of turn");
  a_lanes_apart: assert property (p_lanes_apart) else $error("both lanes high");
  a_f_hold: assert property (p_f_hold) else $error("low rate pulse cut short");
  a_cal_hold: assert property (p_cal_hold) else $error("calibration pulse cut short");
endmodule // pfc_conv_asserts
bind pfc_converter pfc_conv_asserts #(.F_WIDTH_CYC(F_WIDTH_CYC), .F_MINPER_CYC(F_MINPER_CYC),
  .CAL_WIDTH_CYC(CAL_WIDTH_CYC), .CAL_MINPER_CYC(CAL_MINPER_CYC)) u_chk (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .low_rate_pulse_out_a_out(low_rate_pulse_out_a_out),
  .low_rate_pulse_out_b_out(low_rate_pulse_out_b_out),
  .calibration_pulse_out_out(calibration_pulse_out_out));
`default_nettype wire

// ### verification/pfc_pulse_counter.sv
// Impulse counter model on the far side of the pulse outputs.
// Assumes the pulse lines are synchronous to clk_in.
`default_nettype none
module pfc_pulse_counter (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic lane_a_in,
  input wire logic lane_b_in,
  input wire logic cal_in,
  output int a_count_out,
  output int b_count_out,
  output int cal_count_out,
  output logic b_first_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_q, b_q, c_q;
  // ==========================================================
  // Counts rising edges only, as a stepper counter would
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {a_q, b_q, c_q} <= 3'h0;
      a_count_out <= 0;
      b_count_out <= 0;
      cal_count_out <= 0;
      b_first_out <= 1'h0;
    end else begin
      {a_q, b_q, c_q} <= {lane_a_in, lane_b_in, cal_in};
      if (lane_a_in && !a_q) a_count_out <= a_count_out + 1;
      if (lane_b_in && !b_q) b_count_out <= b_count_out + 1;
      if (lane_b_in && !b_q && a_count_out == 0) b_first_out <= 1'h1;
      if (cal_in && !c_q) cal_count_out <= cal_count_out + 1;
    end
  end
endmodule // pfc_pulse_counter
`default_nettype wire

// ### verification/pfc_converter_bench.sv
// Self-checking bench for the power-to-pulse converter.
// Assumes the counter model and bound checker are compiled with it.
`default_nettype none
module pfc_converter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam real DS = 2000.0;
  // Full-scale dc on three phases: 6.313 * 3 * 0.25 / 2.4^2 of the base rate
  localparam real KDC = 6.313 * 0.75 / 5.76;
  logic clk_in, rst_n_in, dmode, sv;
  logic [2:0] sel;
  logic signed [15:0] v, i;
  wire fa, fb, cal;
  int na, nb, nc;
  logic bfirst;
  int err_total;
  int samples_checked;
  real fbase [8] = '{2.24, 1.12, 5.09, 0.56, 4.49, 4.49, 1.12, 0.56};
  int mult [8] = '{16, 32, 160, 32, 8, 16, 16, 16};
  pfc_converter #(.F_WIDTH_CYC(40), .F_MINPER_CYC(200), .CAL_WIDTH_CYC(30),
    .CAL_MINPER_CYC(70), .DIV_SCALE(32'h000007D0)) i_dut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .scale_select_in(sel[2]), .rate_select_1_in(sel[1]),
    .rate_select_0_in(sel[0]), .delta_mode_in(dmode), .sample_valid_in(sv),
    .volt_a_in(v), .volt_b_in(v), .volt_c_in(v), .curr_a_in(i), .curr_b_in(i),
    .curr_c_in(i), .low_rate_pulse_out_a_out(fa), .low_rate_pulse_out_b_out(fb),
    .calibration_pulse_out_out(cal));
  pfc_pulse_counter i_cnt (.clk_in(clk_in), .rst_n_in(rst_n_in), .lane_a_in(fa),
    .lane_b_in(fb), .cal_in(cal), .a_count_out(na), .b_count_out(nb),
    .cal_count_out(nc), .b_first_out(bfirst));
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================================
  // Compare and control tasks
  task check_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task check_range(input string name, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // Tolerance covers divider truncation and the filter ramp
  task check_near(input string name, input real exp, input int got);
    check_range(name, $rtoi(exp * 0.85) - 1, $rtoi(exp * 1.15) + 2, got);
  endtask
  // Selects only move under reset, so they never change mid-accumulation
  task restart(input logic [2:0] code, input logic d);
    @(negedge clk_in);
    rst_n_in = 1'h0;
    sv = 1'h0;
    sel = code;
    dmode = d;
    repeat (2) @(negedge clk_in);
    check_bit("outputs in reset", 1'h0, fa | fb | cal);
    rst_n_in = 1'h1;
    sv = 1'h1;
  endtask
  task complete_run;
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task t_codes;
    real e;
    for (int k = 0; k < 8; k++) begin
      restart(k[2:0], 1'h0);
      repeat (5000) @(negedge clk_in);
      e = KDC * fbase[k] * mult[k] * DS / 1.0E8 * (5000.0 - 1024.0 * (1.0 - $exp(-5000.0 / 1024.0)));
      check_near("calibration count", e, nc);
    end
  endtask
  task t_low_rate;
    real e;
    restart(3'h2, 1'h0);
    repeat (35000) @(negedge clk_in);
    e = KDC * 5.09 * DS / 1.0E8 * (35000.0 - 1024.0);
    check_near("low rate count", e, na + nb);
    check_range("lane balance", 0, 1, na - nb);
    check_bit("lane b first", 1'h0, bfirst);
  endtask
  task t_delta;
    restart(3'h2, 1'h1);
    repeat (3000) @(negedge clk_in);
    check_range("delta calibration count", 0, 0, nc);
  endtask
  // Three-level ac wave: the product averages half of the dc product
  task t_ac;
    real e;
    restart(3'h2, 1'h0);
    for (int n = 0; n < 5000; n++) begin
      v = (n % 4 == 0) ? 16'h7FFF : ((n % 4 == 2) ? 16'h8001 : 16'h0000);
      i = v;
      @(negedge clk_in);
    end
    e = 0.5 * KDC * 5.09 * 160.0 * DS / 1.0E8;
    e = e * (5000.0 - 1024.0 * (1.0 - $exp(-5000.0 / 1024.0)));
    check_near("ac calibration count", e, nc);
  endtask
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst_n_in = 1'h0;
    sel = 3'h0;
    dmode = 1'h0;
    sv = 1'h0;
    v = 16'h7FFF;
    i = 16'h7FFF;
    t_codes;
    t_low_rate;
    t_delta;
    t_ac;
    complete_run;
  end
endmodule // pfc_converter_bench
`default_nettype wire
